// File: verilog/fms_defines.svh
// timing counts, page and word sizes and fixed values of the flash sequencer
`ifndef FMS_DEFINES_SVH
`define FMS_DEFINES_SVH
`define FMS_CLK_HZ 25000000
`define FMS_PROG_TIME_NS 1250000
`define FMS_ERASE_TIME_NS 100000000
`define FMS_RECOVER_TIME_NS 2000000
`define FMS_PROG_CYCLES ((`FMS_PROG_TIME_NS / 1000) * (`FMS_CLK_HZ / 1000000))
`define FMS_ERASE_CYCLES ((`FMS_ERASE_TIME_NS / 1000) * (`FMS_CLK_HZ / 1000000))
`define FMS_RECOVER_CYCLES ((`FMS_RECOVER_TIME_NS / 1000) * (`FMS_CLK_HZ / 1000000))
`define FMS_PAGE_WORDS 128
`define FMS_DATA_W 32
`define FMS_ERASED_WORD 32'hffffffff
`define FMS_GEAR_FULL 2'h0
`endif

// File: verilog/fms_pkg.sv
// types shared by the flash sequencer files
package fms_pkg;
	typedef enum logic [1:0] {
		FMS_CMD_NONE,
		FMS_CMD_PROG,
		FMS_CMD_ERASE
	} fms_cmd_t;
	typedef enum logic [1:0] {
		FMS_ST_READ,
		FMS_ST_PROG,
		FMS_ST_ERASE,
		FMS_ST_RECOVER
	} fms_state_t;
endpackage

// File: verilog/fms_timer.sv
// down counter timing the automatic program, erase and recovery intervals
`timescale 1ns/1ps
module fms_timer #(
	parameter int CW = 32
)(
	input wire logic clock,
	input wire logic rst,
	input wire logic load,
	input wire logic [CW-1:0] count,
	output logic done
);
	typedef struct packed {
		logic [CW-1:0] cnt;
		logic done;
	} fms_tmr_t;
	fms_tmr_t st_r;
	fms_tmr_t st_nxt;
	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.done = 1'b0;
		if (load)
			st_nxt.cnt = count;
		else if (st_r.cnt != '0)
		begin
			st_nxt.cnt = st_r.cnt - 1'b1;
			st_nxt.done = (st_r.cnt == {{(CW-1){1'b0}}, 1'b1}); // one-cycle pulse at expiry
		end
	end
	// registers
	always_ff @(posedge clock)
	begin
		if (rst)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end
	assign done = st_r.done;
endmodule

// File: verilog/fms_top.sv
// flash sequencer: read path, automatic page program and block erase, protection, boot mode
`timescale 1ns/1ps
`include "fms_defines.svh"
module fms_top
	import fms_pkg::*;
#(
	parameter int BLOCKS = 8,
	parameter int BLK_W = 3,
	parameter int WORD_W = 15,
	parameter int PAGE_WORDS = `FMS_PAGE_WORDS,
	parameter int CW = 32,
	parameter logic [CW-1:0] PROG_CYCLES = CW'(`FMS_PROG_CYCLES),
	parameter logic [CW-1:0] ERASE_CYCLES = CW'(`FMS_ERASE_CYCLES),
	parameter logic [CW-1:0] RECOVER_CYCLES = CW'(`FMS_RECOVER_CYCLES)
)(
	input wire logic clock,
	input wire logic rst,
	input wire logic boot_select_port_bit,
	input wire logic rd_req,
	input wire logic rd_external,
	input wire logic [BLK_W-1:0] rd_block,
	input wire logic [WORD_W-1:0] rd_word,
	input wire logic [`FMS_DATA_W-1:0] arr_rdata,
	input wire fms_cmd_t cmd,
	input wire logic [BLK_W-1:0] cmd_block,
	input wire logic [WORD_W-1:0] cmd_page_word,
	input wire logic prot_set,
	input wire logic [BLK_W-1:0] prot_block,
	input wire logic read_prot_set,
	output logic [`FMS_DATA_W-1:0] rd_data,
	output logic rd_valid,
	output logic rd_refused,
	output logic busy,
	output logic cmd_done,
	output logic cmd_rejected,
	output logic single_boot,
	output logic [1:0] clock_gear,
	output logic arr_prog_en,
	output logic arr_erase_en,
	output logic [BLK_W-1:0] arr_block,
	output logic [WORD_W-1:0] arr_page_base
);
	typedef struct packed {
		fms_state_t state;
		logic [BLOCKS-1:0] wprot;
		logic read_prot;
		logic was_rst;
		logic interrupted;
		logic [`FMS_DATA_W-1:0] rd_data;
		logic rd_valid;
		logic rd_refused;
		logic busy;
		logic cmd_done;
		logic cmd_rejected;
		logic single_boot;
		logic [1:0] gear;
		logic prog_en;
		logic erase_en;
		logic [BLK_W-1:0] blk;
		logic [WORD_W-1:0] page_base;
	} fms_st_t;

	fms_st_t st_r;
	fms_st_t st_nxt;
	logic tmr_load;
	logic [CW-1:0] tmr_count;
	logic tmr_done;

	// first word of the page holding a word address
	function automatic logic [WORD_W-1:0] page_of(input logic [WORD_W-1:0] w);
		page_of = w & ~WORD_W'(PAGE_WORDS - 1);
	endfunction

	// ----------------------------------------
	// interval timer
	// ----------------------------------------
	fms_timer #(
		.CW(CW)
	) u_timer (
		.clock(clock),
		.rst(rst),
		.load(tmr_load),
		.count(tmr_count),
		.done(tmr_done)
	);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb
	begin
		st_nxt = st_r;
		tmr_load = 1'b0;
		tmr_count = '0;
		st_nxt.rd_valid = 1'b0;
		st_nxt.rd_refused = 1'b0;
		st_nxt.cmd_done = 1'b0;
		st_nxt.cmd_rejected = 1'b0;
		st_nxt.was_rst = 1'b0;
		st_nxt.gear = `FMS_GEAR_FULL;
		// first edge after reset release: catch strap, start recovery if needed
		if (st_r.was_rst)
		begin
			st_nxt.single_boot = ~boot_select_port_bit; // low pin picks serial boot
			if (st_r.interrupted)
			begin
				st_nxt.state = FMS_ST_RECOVER;
				st_nxt.busy = 1'b1;
				tmr_load = 1'b1;
				tmr_count = RECOVER_CYCLES;
			end
		end
		// protection only through software commands, no voltage method
		if (prot_set)
			st_nxt.wprot[prot_block] = 1'b1;
		if (read_prot_set)
			st_nxt.read_prot = 1'b1;
		// read path, full 32-bit word
		if (rd_req)
		begin
			if (rd_external && st_r.read_prot)
				st_nxt.rd_refused = 1'b1;
			else if (st_r.state != FMS_ST_READ || st_r.was_rst)
				st_nxt.rd_refused = 1'b1; // busy or recovering gives no data
			else
			begin
				st_nxt.rd_valid = 1'b1;
				st_nxt.rd_data = arr_rdata;
			end
		end
		unique case (st_r.state)
			FMS_ST_READ:
			begin
				if (cmd != FMS_CMD_NONE && !st_r.was_rst)
				begin
					if (st_r.wprot[cmd_block])
						st_nxt.cmd_rejected = 1'b1;
					else
					begin
						// per-block, one page per command
						st_nxt.blk = cmd_block;
						st_nxt.page_base = page_of(cmd_page_word);
						st_nxt.busy = 1'b1;
						st_nxt.interrupted = 1'b1; // remembered across a reset
						tmr_load = 1'b1; // automatic sequencing
						if (cmd == FMS_CMD_PROG)
						begin
							st_nxt.state = FMS_ST_PROG;
							st_nxt.prog_en = 1'b1;
							tmr_count = PROG_CYCLES; // fixed length, any word count
						end
						else
						begin
							st_nxt.state = FMS_ST_ERASE;
							st_nxt.erase_en = 1'b1;
							tmr_count = ERASE_CYCLES;
						end
					end
				end
			end
			FMS_ST_PROG, FMS_ST_ERASE:
			begin
				if (cmd != FMS_CMD_NONE)
					st_nxt.cmd_rejected = 1'b1;
				if (tmr_done)
				begin
					st_nxt.state = FMS_ST_READ;
					st_nxt.busy = 1'b0;
					st_nxt.prog_en = 1'b0;
					st_nxt.erase_en = 1'b0;
					st_nxt.interrupted = 1'b0;
					st_nxt.cmd_done = 1'b1;
				end
			end
			FMS_ST_RECOVER:
			begin
				if (cmd != FMS_CMD_NONE)
					st_nxt.cmd_rejected = 1'b1;
				if (tmr_done && !st_r.was_rst)
				begin
					st_nxt.state = FMS_ST_READ;
					st_nxt.busy = 1'b0;
					st_nxt.interrupted = 1'b0;
				end
			end
		endcase
	end

	// ----------------------------------------
	// registers; reset returns to read mode but keeps the interrupted mark
	// ----------------------------------------
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			st_r <= '0; // normal read mode
			st_r.state <= FMS_ST_READ;
			st_r.was_rst <= 1'b1;
			st_r.single_boot <= 1'b0;
			st_r.interrupted <= st_r.interrupted; // operation cut short is remembered
			st_r.wprot <= st_r.wprot; // protection lives in the array
			st_r.read_prot <= st_r.read_prot;
		end
		else
			st_r <= st_nxt;
	end

	assign rd_data = st_r.rd_data;
	assign rd_valid = st_r.rd_valid;
	assign rd_refused = st_r.rd_refused;
	assign busy = st_r.busy;
	assign cmd_done = st_r.cmd_done;
	assign cmd_rejected = st_r.cmd_rejected;
	assign single_boot = st_r.single_boot;
	assign clock_gear = st_r.gear;
	assign arr_prog_en = st_r.prog_en;
	assign arr_erase_en = st_r.erase_en;
	assign arr_block = st_r.blk;
	assign arr_page_base = st_r.page_base;
endmodule

// File: verif/fms_array_model.sv
// flash array stand-in giving a word derived from the read address
`timescale 1ns/1ps
module fms_array_model (
	input wire logic [2:0] rd_block,
	input wire logic [14:0] rd_word,
	output logic [31:0] arr_rdata
);
	// address in the data, so a word from the wrong place shows
	assign arr_rdata = {rd_word, rd_block, 14'h2a5b};
endmodule

// File: verif/fms_chk.sv
// port assertions of the flash sequencer
`timescale 1ns/1ps
module fms_chk
	import fms_pkg::*;
#(
	parameter int PC = 20,
	parameter int EC = 40
)(
	input wire logic clock,
	input wire logic rst,
	input wire logic boot_select_port_bit,
	input wire logic rd_req,
	input wire logic rd_external,
	input wire logic [31:0] arr_rdata,
	input wire fms_cmd_t cmd,
	input wire logic [31:0] rd_data,
	input wire logic rd_valid,
	input wire logic rd_refused,
	input wire logic busy,
	input wire logic cmd_done,
	input wire logic cmd_rejected,
	input wire logic single_boot,
	input wire logic [1:0] clock_gear,
	input wire logic arr_prog_en,
	input wire logic arr_erase_en,
	input wire logic [14:0] arr_page_base
);
	// ----------------
	// timing relations
	// ----------------
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// done pulse lands one cycle after the timer expiry, so one more than the count
	localparam int PD = PC + 1;
	localparam int ED = EC + 1;
	sequence s_prog; $rose(arr_prog_en); endsequence
	sequence s_erase; $rose(arr_erase_en); endsequence
	chk_prog_length: assert property (s_prog |-> ##PD cmd_done)
		else $error("program length wrong");
	chk_erase_length: assert property (s_erase |-> ##ED cmd_done)
		else $error("erase length wrong");
	chk_page_align: assert property (s_prog |-> arr_page_base[6:0] == 7'h00)
		else $error("page base not aligned");
	chk_read_answer: assert property (rd_req && !busy && !rd_external |=> rd_valid && rd_data == $past(arr_rdata))
		else $error("read answer wrong");
	chk_busy_refuse: assert property (rd_req && busy |=> rd_refused && !rd_valid)
		else $error("read served while busy");
	chk_busy_reject: assert property (busy && cmd != FMS_CMD_NONE |=> cmd_rejected)
		else $error("command taken while busy");
	chk_gear_full: assert property (clock_gear == 2'h0)
		else $error("clock gear not full");
	chk_boot_latch: assert property ($fell(rst) |=> single_boot == !$past(boot_select_port_bit))
		else $error("boot mode wrong");
endmodule
bind fms_top fms_chk #(.PC(PROG_CYCLES), .EC(ERASE_CYCLES)) fms_chk_i (.*);

// File: verif/fms_top_tb.sv
// self-checking bench of the flash sequencer
`timescale 1ns/1ps
module fms_top_tb;
	import fms_pkg::*;
	localparam int PC = 20;
	localparam int EC = 40;
	localparam int RC = 30;
	logic clock = 0, rst = 1, boot_select_port_bit = 0, rd_req = 0, rd_external = 0;
	logic prot_set = 0, read_prot_set = 0;
	logic [2:0] rd_block = 0, cmd_block = 0, prot_block = 0, arr_block;
	logic [14:0] rd_word = 0, cmd_page_word = 0, arr_page_base;
	logic [31:0] arr_rdata, rd_data;
	fms_cmd_t cmd = FMS_CMD_NONE;
	logic rd_valid, rd_refused, busy, cmd_done, cmd_rejected, single_boot, arr_prog_en, arr_erase_en;
	logic [1:0] clock_gear;
	int err_total = 0, checks = 0, n;
	int rp = 0; // model: read protection state
	always #20 clock = ~clock;
	fms_array_model fms_array_model_i (.*);
	fms_top #(.PROG_CYCLES(32'd20), .ERASE_CYCLES(32'd40), .RECOVER_CYCLES(32'd30)) fms_top_i (.*);
	// ------------
	// shared tasks
	// ------------
	task tick;
		@(posedge clock);
		#1;
	endtask
	task ck(input logic ok, input string m);
		checks++;
		if (ok !== 1'b1)
		begin
			err_total++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask
	task summarize;
		$display("checks %0d errors %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// random address; expected word follows the array pattern
	task rd(input logic ext);
		rd_block = $urandom;
		rd_word = $urandom;
		rd_external = ext;
		rd_req = 1;
		tick;
		rd_req = 0;
		if (ext && rp == 1)
			ck(rd_refused && !rd_valid, "read not refused");
		else
			ck(rd_valid && rd_data === {rd_word, rd_block, 14'h2a5b}, "read data");
		// spacer so the next request is not raised in the step that lowered this one
		tick;
	endtask
	// len 0 means the command must be rejected
	task op(input fms_cmd_t c, input logic [2:0] blk, input int len);
		cmd = c;
		cmd_block = blk;
		cmd_page_word = $urandom;
		tick;
		cmd = FMS_CMD_NONE;
		if (len == 0)
			ck(cmd_rejected && !busy, "command not rejected");
		else
		begin
			ck(busy && arr_block === blk, "not started");
			ck(c != FMS_CMD_PROG || arr_page_base === (cmd_page_word & 15'h7f80), "page base");
			n = 0;
			while (cmd_done !== 1'b1 && n < 200)
			begin
				tick;
				n++;
				rd_req = (n == 2);
				cmd = (n == 2) ? FMS_CMD_PROG : FMS_CMD_NONE;
				if (n == 3)
					ck(rd_refused && cmd_rejected, "busy refusal");
			end
			ck(n == len + 1 && !busy, "op length");
			if (n >= 200)
				summarize;
		end
		// spacer so a following command is not raised in the step that lowered this one
		tick;
	endtask
	initial
	begin
		void'($urandom(32'hd1ec91bb));
		// power-on hold shortened to 16 clocks; the design has no minimum of its own
		repeat (16) tick;
		rst = 0;
		tick;
		tick;
		ck(single_boot && clock_gear === 2'h0 && !busy, "reset state");
		repeat (3) rd(0);
		rd(1);
		op(FMS_CMD_PROG, 1, PC);
		op(FMS_CMD_ERASE, 2, EC);
		prot_block = 3;
		prot_set = 1;
		tick;
		prot_set = 0;
		op(FMS_CMD_PROG, 3, 0);
		op(FMS_CMD_PROG, 4, PC);
		read_prot_set = 1;
		tick;
		read_prot_set = 0;
		rp = 1;
		rd(1);
		rd(0);
		// cut a running erase by reset, boot pin now high
		cmd = FMS_CMD_ERASE;
		tick;
		cmd = FMS_CMD_NONE;
		repeat (5) tick;
		rst = 1;
		boot_select_port_bit = 1;
		repeat (16) tick; // 640 ns, above the minimum hold
		rst = 0;
		tick;
		n = 0;
		while (busy === 1'b1 && n < 200)
		begin
			tick;
			n++;
		end
		ck(n >= RC - 1 && n <= RC + 1 && !single_boot, "recovery");
		rd(0);
		rd(1);
		summarize;
	end
endmodule
